// >>> design/apc_regs.svh
`ifndef APC_REGS_SVH
`define APC_REGS_SVH

// ==================================================
// register offsets (byte addresses)
`define APC_OFS_CTL2     8'h00
`define APC_OFS_STAT     8'h04
`define APC_OFS_DFS      8'h08
`define APC_OFS_MCR      8'h0C
`define APC_PLL0_TAG     3'h1
`define APC_PLL1_TAG     3'h2
`define APC_OUT_BIT      7

// ==================================================
// per-apll sub-register index (address bits 4:2)
`define APC_SUB_CTL1     3'h0
`define APC_SUB_FB0      3'h1
`define APC_SUB_FB1      3'h2
`define APC_SUB_FB2      3'h3
`define APC_SUB_REM      3'h4
`define APC_SUB_DEN      3'h5
`define APC_SUB_BP       3'h6

// ==================================================
// field positions
`define APC_C2_PRI_LSB   0
`define APC_C2_ALT_LSB   3
`define APC_C2_DIV_LSB   6
`define APC_C2_EXT_BIT   8
`define APC_C1_EN_BIT    0
`define APC_C1_HS_LSB    8
`define APC_DFS_CODE_LSB 0
`define APC_DFS_MULT_LSB 16

// ==================================================
// codes and reset values
`define APC_MUX_DPLL     3'h4
`define APC_DFS_PROG     4'hF
`define APC_DFS_MIN      16'h4BF0
`define APC_DFS_MAX      16'h97E0
`define APC_HS_RST       8'h06
`define APC_BP_RST       7'h2A
`define APC_FMT_DIS      3'h0
`define APC_FMT_CML      3'h1
`define APC_FMT_CML_HALF 3'h2
`define APC_FMT_HSTL     3'h3
`define APC_FMT_CMOS1    3'h4
`define APC_FMT_CMOS_IN  3'h5
`define APC_FMT_CMOS_INV 3'h6

`endif

// >>> design/apc_pkg.sv
package apc_pkg;

    typedef struct packed {
        logic       ext_sw;
        logic [1:0] in_div;
        logic [2:0] alt_sel;
        logic [2:0] pri_sel;
    } apc_ctl2_s;

    typedef struct packed {
        logic [74:0] div;
        logic [31:0] rem;
        logic [31:0] den;
        logic [6:0]  bp;
    } apc_fb_s;

    typedef struct packed {
        logic [2:0] sel;
        logic       apll_only;
        logic       dpll_apll;
        logic [1:0] in_div;
    } apc_mux_s;

    typedef struct packed {
        logic [3:0]  code;
        logic [15:0] mult;
        logic        prog_mode;
        logic        out_of_band;
    } apc_synth_s;

    typedef struct packed {
        logic cml;
        logic half_swing;
        logic hstl;
        logic low_power;
    } apc_drv_s;

endpackage

// >>> design/apc_hs_div.sv
`timescale 1ns/1ns
`default_nettype none

module apc_hs_div #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // control
    input  wire logic         en,
    input  wire logic [W-1:0] ratio,
    // vco edges in, divided clock out
    input  wire logic         vco_edge,
    output logic              clk_out
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         out;
    } apc_div_s;

    apc_div_s     st;
    apc_div_s     nx;
    logic [W-1:0] lim;

    // each vco edge is half a vco period, so toggling every ratio edges
    // gives equal high and low times for odd ratios too
    assign lim = (ratio == '0) ? '0 : ratio - 1'b1;

    always_comb begin
        nx = st;
        if (!en) begin
            nx = '0;
        end else if (vco_edge) begin
            if (st.cnt >= lim) begin
                nx.cnt = '0;
                nx.out = ~st.out;
            end else begin
                nx.cnt = st.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= nx;
        end
    end

    assign clk_out = st.out;

    toggle_end_a: assert property (@(posedge clk) disable iff (rst)
        ce && en && vco_edge && st.cnt >= lim |=> clk_out != $past(clk_out))
        else $error("divider missed its toggle");
    hold_mid_a: assert property (@(posedge clk) disable iff (rst)
        ce && en && !vco_edge |=> clk_out == $past(clk_out))
        else $error("divider toggled without an edge");

endmodule // apc_hs_div

`default_nettype wire

// >>> design/apc_top.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "apc_regs.svh"

// ==================================================
// apll input mux, synth mode, apll control and output config
module apc_top #(
    parameter int NUM_OUT = 10,
    parameter int HS_W    = 8
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    // register port
    input  wire logic [7:0]                 addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [31:0]                rdata,
    // pins and vco edge ticks
    input  wire logic                       sw_pin,
    input  wire logic [1:0]                 vco_edge,
    // apll control
    output apc_pkg::apc_mux_s               mux,
    output logic      [1:0]                 apll_run,
    output logic      [1:0]                 apll_relock,
    output apc_pkg::apc_fb_s [1:0]          fb_act,
    output apc_pkg::apc_synth_s             synth,
    // output pins and driver modes
    output logic      [NUM_OUT-1:0]         oc_pos,
    output logic      [NUM_OUT-1:0]         oc_neg,
    output logic      [NUM_OUT-1:0]         oc_pos_oe_n,
    output logic      [NUM_OUT-1:0]         oc_neg_oe_n,
    output apc_pkg::apc_drv_s [NUM_OUT-1:0] oc_drv
);

    typedef struct packed {
        apc_pkg::apc_ctl2_s               ctl2;
        logic [1:0]                       en;
        logic [1:0][HS_W-1:0]             hs;
        apc_pkg::apc_fb_s [1:0]           fb_wr;
        apc_pkg::apc_fb_s [1:0]           fb_act;
        logic [1:0]                       relock;
        apc_pkg::apc_synth_s              synth;
        logic [3:0]                       bank_pll;
        logic [NUM_OUT-1:0][2:0]          fmt;
        logic [1:0]                       pin_sync;
        apc_pkg::apc_mux_s                mux;
        logic [31:0]                      rdata;
        logic [NUM_OUT-1:0]               pos;
        logic [NUM_OUT-1:0]               neg;
        logic [NUM_OUT-1:0]               pos_oe_n;
        logic [NUM_OUT-1:0]               neg_oe_n;
        apc_pkg::apc_drv_s [NUM_OUT-1:0]  drv;
    } apc_top_s;

    apc_top_s   st;
    apc_top_s   nx;
    logic [1:0] hs_clk;

    // ==================================================
    // helpers
    function automatic logic [1:0] bank_of(int i);
        if (i < 2) begin
            return 2'h0;
        end else if (NUM_OUT > 5) begin
            return (i < 5) ? 2'h1 : (i < 8) ? 2'h2 : 2'h3;
        end else begin
            return (i == 2) ? 2'h1 : (i == 3) ? 2'h2 : 2'h3;
        end
    endfunction

    function automatic logic [2:0] eff_sel(apc_pkg::apc_ctl2_s c, logic pin);
        return (c.ext_sw && pin) ? c.alt_sel : c.pri_sel;
    endfunction

    function automatic logic pll_hit(logic [7:0] a);
        return a[7:5] == `APC_PLL0_TAG || a[7:5] == `APC_PLL1_TAG;
    endfunction

    function automatic logic out_hit(logic [7:0] a);
        return a[`APC_OUT_BIT] && int'(a[6:2]) < NUM_OUT;
    endfunction

    function automatic logic [31:0] rd_word(apc_top_s s, logic [7:0] a);
        logic [31:0] w;
        logic        p;
        w = 32'h0;
        p = a[6];
        if (a == `APC_OFS_CTL2) begin
            w[`APC_C2_PRI_LSB +: 3] = s.ctl2.pri_sel;
            w[`APC_C2_ALT_LSB +: 3] = s.ctl2.alt_sel;
            w[`APC_C2_DIV_LSB +: 2] = s.ctl2.in_div;
            w[`APC_C2_EXT_BIT]      = s.ctl2.ext_sw;
        end else if (a == `APC_OFS_STAT) begin
            w[7:0] = {s.synth.prog_mode, s.synth.out_of_band, s.en,
                      s.pin_sync[1], s.mux.sel};
        end else if (a == `APC_OFS_DFS) begin
            w[`APC_DFS_CODE_LSB +: 4]  = s.synth.code;
            w[`APC_DFS_MULT_LSB +: 16] = s.synth.mult;
        end else if (a == `APC_OFS_MCR) begin
            w[3:0] = s.bank_pll;
        end else if (pll_hit(a)) begin
            case (a[4:2])
                `APC_SUB_CTL1: begin
                    w[`APC_C1_EN_BIT]          = s.en[p];
                    w[`APC_C1_HS_LSB +: HS_W]  = s.hs[p];
                end
                `APC_SUB_FB0: w = s.fb_wr[p].div[31:0];
                `APC_SUB_FB1: w = s.fb_wr[p].div[63:32];
                `APC_SUB_FB2: w[10:0] = s.fb_wr[p].div[74:64];
                `APC_SUB_REM: w = s.fb_wr[p].rem;
                `APC_SUB_DEN: w = s.fb_wr[p].den;
                `APC_SUB_BP:  w[6:0] = s.fb_wr[p].bp;
                default: w = 32'h0;
            endcase
        end else if (out_hit(a)) begin
            w[2:0] = s.fmt[a[6:2]];
        end
        return w;
    endfunction

    // ==================================================
    // high-speed dividers, one per apll
    for (genvar g = 0; g < 2; g++) begin : g_hs
        apc_hs_div #(
            .W (HS_W)
        ) u_div (
            .clk      (clk),
            .rst      (rst),
            .ce       (ce),
            .en       (st.en[g]),
            .ratio    (st.hs[g]),
            .vco_edge (vco_edge[g]),
            .clk_out  (hs_clk[g])
        );
    end

    // ==================================================
    // next state
    always_comb begin
        logic       p;
        logic       src;
        logic [2:0] f;
        p  = addr[6];
        src = 1'b0;
        f   = 3'h0;
        nx = st;
        nx.rdata    = 32'h0;
        nx.pin_sync = {st.pin_sync[0], sw_pin};
        if (wr) begin
            if (addr == `APC_OFS_CTL2) begin
                nx.ctl2.pri_sel = wdata[`APC_C2_PRI_LSB +: 3];
                nx.ctl2.alt_sel = wdata[`APC_C2_ALT_LSB +: 3];
                nx.ctl2.in_div  = wdata[`APC_C2_DIV_LSB +: 2];
                nx.ctl2.ext_sw  = wdata[`APC_C2_EXT_BIT];
            end else if (addr == `APC_OFS_DFS) begin
                nx.synth.code = wdata[`APC_DFS_CODE_LSB +: 4];
                nx.synth.mult = wdata[`APC_DFS_MULT_LSB +: 16];
            end else if (addr == `APC_OFS_MCR) begin
                nx.bank_pll = wdata[3:0];
            end else if (pll_hit(addr)) begin
                case (addr[4:2])
                    `APC_SUB_CTL1: begin
                        nx.en[p] = wdata[`APC_C1_EN_BIT];
                        nx.hs[p] = wdata[`APC_C1_HS_LSB +: HS_W];
                    end
                    `APC_SUB_FB0: nx.fb_wr[p].div[31:0]  = wdata;
                    `APC_SUB_FB1: nx.fb_wr[p].div[63:32] = wdata;
                    `APC_SUB_FB2: nx.fb_wr[p].div[74:64] = wdata[10:0];
                    `APC_SUB_REM: nx.fb_wr[p].rem = wdata;
                    `APC_SUB_DEN: nx.fb_wr[p].den = wdata;
                    `APC_SUB_BP:  nx.fb_wr[p].bp  = wdata[6:0];
                    default: ;
                endcase
            end else if (out_hit(addr)) begin
                nx.fmt[addr[6:2]] = wdata[2:0];
            end
        end
        if (rd) begin
            nx.rdata = rd_word(st, addr);
        end
        // feedback settings take effect only on an enable rise
        for (int i = 0; i < 2; i++) begin
            nx.relock[i] = nx.en[i] & ~st.en[i];
            if (nx.relock[i]) begin
                nx.fb_act[i] = nx.fb_wr[i];
            end
        end
        nx.synth.prog_mode   = nx.synth.code == `APC_DFS_PROG;
        nx.synth.out_of_band = nx.synth.prog_mode &&
            (nx.synth.mult < `APC_DFS_MIN || nx.synth.mult > `APC_DFS_MAX);
        nx.mux.sel       = eff_sel(st.ctl2, st.pin_sync[1]);
        nx.mux.apll_only = ~nx.mux.sel[2];
        nx.mux.dpll_apll = nx.mux.sel == `APC_MUX_DPLL;
        nx.mux.in_div    = st.ctl2.in_div;
        for (int i = 0; i < NUM_OUT; i++) begin
            src = hs_clk[st.bank_pll[bank_of(i)]];
            f   = st.fmt[i];
            nx.pos[i]      = src;
            nx.neg[i]      = ~src;
            nx.pos_oe_n[i] = 1'b0;
            nx.neg_oe_n[i] = 1'b0;
            nx.drv[i]      = '0;
            case (f)
                `APC_FMT_CML, `APC_FMT_CML_HALF: begin
                    nx.drv[i].cml        = 1'b1;
                    nx.drv[i].half_swing = f == `APC_FMT_CML_HALF;
                end
                `APC_FMT_HSTL: nx.drv[i].hstl = 1'b1;
                `APC_FMT_CMOS1: begin
                    nx.neg[i]      = 1'b0;
                    nx.neg_oe_n[i] = 1'b1;
                end
                `APC_FMT_CMOS_IN:  nx.neg[i] = src;
                `APC_FMT_CMOS_INV: nx.neg[i] = ~src;
                default: begin
                    nx.pos[i]           = 1'b0;
                    nx.neg[i]           = 1'b0;
                    nx.pos_oe_n[i]      = 1'b1;
                    nx.neg_oe_n[i]      = 1'b1;
                    nx.drv[i].low_power = 1'b1;
                end
            endcase
        end
    end

    // ==================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st          <= '0;
            st.pos_oe_n <= '1;
            st.neg_oe_n <= '1;
            for (int i = 0; i < NUM_OUT; i++) begin
                st.drv[i].low_power <= 1'b1;
            end
            for (int i = 0; i < 2; i++) begin
                st.hs[i]        <= HS_W'(`APC_HS_RST);
                st.fb_wr[i].bp  <= `APC_BP_RST;
                st.fb_act[i].bp <= `APC_BP_RST;
            end
        end else if (ce) begin
            st <= nx;
        end
    end

    assign rdata       = st.rdata;
    assign mux         = st.mux;
    assign apll_run    = st.en;
    assign apll_relock = st.relock;
    assign fb_act      = st.fb_act;
    assign synth       = st.synth;
    assign oc_pos      = st.pos;
    assign oc_neg      = st.neg;
    assign oc_pos_oe_n = st.pos_oe_n;
    assign oc_neg_oe_n = st.neg_oe_n;
    assign oc_drv      = st.drv;

    // ==================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence pin_high_s;
        ce && sw_pin ##1 ce && sw_pin ##1 ce;
    endsequence

    sequence en_rise_s;
        ce && wr && addr[7:5] == `APC_PLL0_TAG && addr[4:2] == `APC_SUB_CTL1
            && wdata[`APC_C1_EN_BIT] && !st.en[0];
    endsequence

    prim_sel_a: assert property (
        ce && !st.ctl2.ext_sw |=> st.mux.sel == $past(st.ctl2.pri_sel))
        else $error("primary field not steering mux");
    alt_sel_a: assert property (
        ce && st.ctl2.ext_sw && st.pin_sync[1] |=> st.mux.sel == $past(st.ctl2.alt_sel))
        else $error("alternate field not steering mux");
    apll_only_a: assert property (
        ce && !st.ctl2.ext_sw && !st.ctl2.pri_sel[2] |=> st.mux.apll_only && !st.mux.dpll_apll)
        else $error("apll-only mode not flagged");
    dpll_mode_a: assert property (
        ce && !st.ctl2.ext_sw && st.ctl2.pri_sel == `APC_MUX_DPLL |=> st.mux.dpll_apll)
        else $error("dpll plus apll mode not flagged");
    pin_sync_a: assert property (
        pin_high_s |-> st.pin_sync[1])
        else $error("select pin not synchronised in two cycles");
    relock_load_a: assert property (
        en_rise_s |=> st.relock[0] && st.fb_act[0] == $past(st.fb_wr[0]))
        else $error("enable rise did not apply feedback settings");
    fb_hold_a: assert property (
        !nx.relock[0] |=> $stable(st.fb_act[0]))
        else $error("feedback settings changed without enable rise");
    off_hiz_a: assert property (
        ce && st.fmt[0] == `APC_FMT_DIS |=> oc_pos_oe_n[0] && oc_neg_oe_n[0]
            && oc_drv[0].low_power)
        else $error("disabled output still driven");
    cmos_inv_a: assert property (
        ce && st.fmt[0] == `APC_FMT_CMOS_INV |=> oc_neg[0] == !oc_pos[0])
        else $error("inverted cmos pin not inverted");
    bank_route_a: assert property (
        ce && st.fmt[0] == `APC_FMT_CML |=> oc_pos[0] == $past(hs_clk[st.bank_pll[0]]))
        else $error("bank a not routed from selected apll");

endmodule // apc_top

`default_nettype wire

// >>> verification/apll_input_mux_and_output_config_bench.sv
`timescale 1ns/1ns
`default_nettype none

module apll_input_mux_and_output_config_bench;

    localparam int N = 10;

    logic                      clk;
    logic                      rst;
    logic                      ce;
    logic                      wr;
    logic                      rd;
    logic                      sw_pin;
    logic [7:0]                addr;
    logic [31:0]               wdata;
    logic [31:0]               rdata;
    logic [1:0]                vco_edge;
    logic [1:0]                apll_run;
    logic [1:0]                apll_relock;
    apc_pkg::apc_mux_s         mux;
    apc_pkg::apc_fb_s [1:0]    fb_act;
    apc_pkg::apc_synth_s       synth;
    logic [N-1:0]              oc_pos;
    logic [N-1:0]              oc_neg;
    logic [N-1:0]              oc_pos_oe_n;
    logic [N-1:0]              oc_neg_oe_n;
    apc_pkg::apc_drv_s [N-1:0] oc_drv;
    int                        failures;
    int                        checks;
    int                        relocks;
    int                        run;
    logic [31:0]               ctl, d, f0, f1, f2, rm, dn;
    logic [15:0]               m;
    logic [3:0]                code;
    logic [2:0]                sel;
    logic                      prog, oob, prev, seen;
    logic [15:0]               edges [4] = '{16'h4BEF, 16'h4BF0, 16'h97E0, 16'h97E1};

    apc_top #(.NUM_OUT(N), .HS_W(8)) DUT (
        .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sw_pin(sw_pin), .vco_edge(vco_edge), .mux(mux),
        .apll_run(apll_run), .apll_relock(apll_relock), .fb_act(fb_act), .synth(synth),
        .oc_pos(oc_pos), .oc_neg(oc_neg), .oc_pos_oe_n(oc_pos_oe_n),
        .oc_neg_oe_n(oc_neg_oe_n), .oc_drv(oc_drv)
    );

    // ==================================================
    // clock, pulse monitor, watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (apll_relock[0] === 1'b1) relocks <= relocks + 1;
    end

    initial begin
        #(40 * 20000);
        failures++;
        end_sim();
    end

    // ==================================================
    // shared tasks
    task automatic check(input logic [145:0] got, input logic [145:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask

    // driver mode and enables expected per format code: {cml,half,hstl,lowp,pos_oe_n,neg_oe_n}
    function automatic logic [5:0] fmt_exp(input logic [2:0] f);
        case (f)
            3'h1:    fmt_exp = 6'b1000_00;
            3'h2:    fmt_exp = 6'b1100_00;
            3'h3:    fmt_exp = 6'b0010_00;
            3'h4:    fmt_exp = 6'b0000_01;
            3'h5,
            3'h6:    fmt_exp = 6'b0000_00;
            default: fmt_exp = 6'b0001_11;
        endcase
    endfunction

    task automatic end_sim();
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==================================================
    // main sequence
    initial begin
        rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
        sw_pin = 1'b0; vco_edge = 2'b00; failures = 0; checks = 0; relocks = 0;
        void'($urandom(30045));
        repeat (4) @(posedge clk);
        check(fb_act[0].bp, 7'h2A);
        check(oc_pos_oe_n, {N{1'b1}});
        check(oc_drv[0].low_power, 1'b1);
        rst <= 1'b0;
        rd_reg(8'h20, d);
        check(d, 32'h0000_0600);
        rd_reg(8'h38, d);
        check(d, 32'h0000_002A);

        // input mux: every primary code, switch off and on, pin both ways
        for (int i = 0; i < 16; i++) begin
            ctl = $urandom_range(0, 511);
            ctl[2:0] = i[2:0];
            ctl[8] = i[3];
            @(posedge clk);
            sw_pin <= i[0];
            wr_reg(8'h00, ctl);
            settle(5);
            sel = (ctl[8] && i[0]) ? ctl[5:3] : ctl[2:0];
            check(mux, {sel, ~sel[2], sel == 3'h4, ctl[7:6]});
            rd_reg(8'h04, d);
            check(d, {28'h0, i[0], sel});
        end

        // synth: all preset codes, then programmable band edges
        for (int i = 0; i < 19; i++) begin
            code = (i < 15) ? i[3:0] : 4'hF;
            m = (i < 15) ? 16'($urandom) : edges[i - 15];
            wr_reg(8'h08, {m, 12'h0, code});
            settle(2);
            prog = (code == 4'hF);
            oob = prog && (m < 16'h4BF0 || m > 16'h97E0);
            check(synth, {code, m, prog, oob});
        end

        // feedback settings apply only on enable rise
        f0 = $urandom; f1 = $urandom; f2 = $urandom; rm = $urandom; dn = $urandom;
        wr_reg(8'h24, f0);
        wr_reg(8'h28, f1);
        wr_reg(8'h2C, f2);
        wr_reg(8'h30, rm);
        wr_reg(8'h34, dn);
        wr_reg(8'h38, 32'h2A);
        settle(3);
        check(fb_act[0], {75'h0, 32'h0, 32'h0, 7'h2A});
        check(relocks, 0);
        wr_reg(8'h20, 32'h0000_0301);
        settle(3);
        check(relocks, 1);
        check(apll_run, 2'b01);
        check(fb_act[0], {f2[10:0], f1, f0, rm, dn, 7'h2A});
        wr_reg(8'h20, 32'h0000_0301);
        settle(3);
        check(relocks, 1);

        // divided clock on bank A, bank D parked on the idle apll
        wr_reg(8'h0C, 32'h8);
        wr_reg(8'h80, 32'h1);
        wr_reg(8'hA4, 32'h1);
        vco_edge <= 2'b11;
        settle(4);
        prev = oc_pos[0];
        run = 0;
        seen = 1'b0;
        repeat (40) begin
            settle(1);
            check(oc_pos[0] ^ oc_neg[0], 1'b1);
            check(oc_pos[9], 1'b0);
            if (oc_pos[0] !== prev) begin
                if (seen) check(run, 3);
                seen = 1'b1;
                run = 1;
                prev = oc_pos[0];
            end else begin
                run++;
            end
        end
        check(seen, 1'b1);
        @(posedge clk);
        vco_edge <= 2'b00;
        wr_reg(8'h20, 32'h0000_0300);
        settle(2);
        check(apll_run, 2'b00);

        // every format code on the first and last output
        for (int i = 0; i < 8; i++) begin
            wr_reg(8'h80, i);
            wr_reg(8'hA4, i);
            settle(2);
            check({oc_drv[0], oc_pos_oe_n[0], oc_neg_oe_n[0]}, fmt_exp(3'(i)));
            check({oc_drv[9], oc_pos_oe_n[9], oc_neg_oe_n[9]}, fmt_exp(3'(i)));
            // apll0 is stopped, so the positive pin rests low
            check({oc_pos[0], oc_neg[0]}, (i == 1 || i == 2 || i == 3 || i == 6) ? 2'b01 : 2'b00);
        end
        rd_reg(8'h80, d);
        check(d, 32'h7);
        wr_reg(8'hA8, 32'h5);
        rd_reg(8'hA8, d);
        check(d, 32'h0);

        // a write while the clock enable is low is lost
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(8'h0C, 32'hF);
        @(posedge clk);
        ce <= 1'b1;
        rd_reg(8'h0C, d);
        check(d, 32'h8);
        end_sim();
    end

endmodule // apll_input_mux_and_output_config_bench

`default_nettype wire
